// File: core/vehi_core.sv
// vector engine host interface: AHB-Lite registers, internal memory, command sequencer
`timescale 1ns/1ps
`default_nettype none
module vehi_core
    import vehi_pkg::*;
(
    input wire logic clk, // 200 MHz system clock
    input wire logic resetn, // synchronous reset, active low
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write when high
    input wire logic [2:0] hsize, // transfer size
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready
    output logic [31:0] hrdata, // read data
    output logic hreadyout, // slave ready
    output logic hresp, // response, always okay
    output logic holdReq, // internal hold request to arbiter
    input wire logic holdAck, // internal hold acknowledge
    output vehi_xreq_t extReq, // external transfer request
    input wire logic extDone, // external transfer complete
    input wire logic [15:0] extRdata, // external read data
    output logic interruptOutN, // halt interrupt, active low
    output logic nmiReq // non-maskable request to core
);
    vehi_state_t s_q; // registered state
    vehi_state_t s_d; // next state
    logic [15:0] ram [RAM_WORDS]; // internal memory, 16-bit words
    logic ramWe; // memory write strobe
    logic [10:0] ramWa; // memory write address
    logic [15:0] ramWd; // memory write data
    logic addrTaken; // address phase accepted
    logic [13:0] aOff; // offset within the window
    logic aIsRam; // address phase hits memory
    logic aIsCtl; // address phase hits an exempt register
    logic aMapped; // address phase hits anything mapped
    logic [10:0] aIdx; // memory index of address phase
    logic [10:0] dIdx; // memory index of data phase
    logic wrPhase; // write data phase now
    logic illegal; // forbidden access while running
    logic stopNow; // termination this cycle
    logic [15:0] cmdWord; // fetched command
    logic [10:0] evenAddr; // aligned operand address
    logic [31:0] accExt; // accumulator in stored operand form

    // pair two words: low from even location, high from odd
    function automatic logic [31:0] pairRead(input logic [10:0] a);
        logic [10:0] e;
        e = {a[10:1], 1'b0};
        pairRead = {ram[e | 11'h001], ram[e]};
    endfunction

    // extended operand to accumulator: drop bit 0, keep sign in 30
    function automatic logic [31:0] extToAcc(input logic [31:0] v);
        extToAcc = {v[31], v[31:1]};
    endfunction

    // accumulator to extended operand, bit 0 forced clear
    function automatic logic [31:0] accToExt(input logic [31:0] a);
        accToExt = {a[30:0], 1'b0};
    endfunction

    // classify an opcode; reserved codes return zero
    function automatic logic opKnown(input logic [4:0] op);
        case (op)
            OP_HALT, OP_BREAK, OP_LX, OP_LY, OP_LZ, OP_LEA, OP_SEA, OP_JMP, OP_EXTLD,
            OP_EXTST: opKnown = 1'b1;
            default: opKnown = 1'b0;
        endcase
    endfunction

    // address decode helpers
    always_comb begin
        addrTaken = hsel && hready && htrans[1];
        aOff = haddr[13:0];
        aIsRam = haddr[13] == OFF_RAM_BASE[13]; // upper half holds memory
        aIdx = haddr[12:2];
        aIsCtl = !aIsRam && (aOff == OFF_STATUS || aOff == OFF_ABORT ||
            aOff == OFF_EXT_HOLD || aOff == OFF_INT_FLAGS || aOff == OFF_INT_MASK ||
            aOff == OFF_NMI_CAUSE);
        aMapped = aIsRam || aIsCtl || aOff == OFF_CMD_PTR || aOff == OFF_ACC;
        dIdx = s_q.phAddr[12:2];
        wrPhase = s_q.phValid && s_q.phWrite;
        // anything mapped but not exempt is forbidden while running
        illegal = addrTaken && s_q.run && aMapped && !aIsCtl;
        cmdWord = ram[s_q.pc];
        evenAddr = {s_q.cmd.arg[10:1], 1'b0};
        accExt = accToExt(s_q.acc); // bit 0 already clear
    end

    // next state: bus slave, control registers and sequencer
    always_comb begin
        s_d = s_q;
        ramWe = 1'b0;
        ramWa = RST_PTR;
        ramWd = RST_WORD[15:0];
        stopNow = 1'b0;
        // a refused access gets no data phase, so its write can never land later
        s_d.phValid = addrTaken && !illegal;
        s_d.phWrite = hwrite;
        s_d.phAddr = aOff;

        // read data is prepared at the address phase so it stands in the data phase
        s_d.rdata = RST_WORD;
        if (addrTaken && !hwrite) begin
            if (illegal) begin
                s_d.rdata = RST_WORD; // forbidden read returns zero while running
            end else if (aIsRam) begin
                s_d.rdata = {16'h0000, ram[aIdx]};
            end else begin
                case (aOff)
                    OFF_CMD_PTR: s_d.rdata = {21'h00_0000, s_q.pc};
                    OFF_STATUS: s_d.rdata = {31'h0000_0000, s_q.run};
                    OFF_EXT_HOLD: s_d.rdata = {31'h0000_0000, s_q.extHold};
                    OFF_INT_FLAGS: s_d.rdata = {31'h0000_0000, s_q.haltFlag};
                    OFF_INT_MASK: s_d.rdata = {31'h0000_0000, s_q.haltMask};
                    OFF_NMI_CAUSE: s_d.rdata = {30'h0000_0000, s_q.undFlag, s_q.errFlag};
                    OFF_ACC: s_d.rdata = accToExt(s_q.acc);
                    default: s_d.rdata = RST_WORD; // unmapped reads zero
                endcase
            end
        end

        // a forbidden access stops the engine at once
        if (illegal) begin
            s_d.errFlag = 1'b1;
            stopNow = 1'b1;
        end

        // write data phase
        if (wrPhase) begin
            if (s_q.phAddr[13]) begin
                // writes while running leave memory alone; one accepted in the cycle the start lands was never flagged
                if (!s_q.run) begin
                    ramWe = 1'b1;
                    ramWa = dIdx;
                    ramWd = hwdata[15:0];
                end
            end else begin
                case (s_q.phAddr)
                    OFF_CMD_PTR: begin
                        if (!s_q.run) begin
                            s_d.pc = hwdata[10:0];
                            s_d.run = 1'b1;
                            s_d.fsm = ST_EXEC;
                        end
                    end
                    OFF_ABORT: begin
                        if (s_q.run) begin
                            stopNow = 1'b1; // any value aborts
                        end
                    end
                    OFF_EXT_HOLD: s_d.extHold = hwdata[BIT_EXTHOLD];
                    OFF_INT_FLAGS: begin
                        // write one clears; a new halt below still wins
                        if (hwdata[BIT_HALT]) begin
                            s_d.haltFlag = 1'b0;
                        end
                    end
                    OFF_INT_MASK: s_d.haltMask = hwdata[BIT_HALT];
                    OFF_NMI_CAUSE: begin
                        if (hwdata[BIT_ERR]) begin
                            s_d.errFlag = illegal; // set in this cycle wins
                        end
                        if (hwdata[BIT_UND]) begin
                            s_d.undFlag = 1'b0;
                        end
                    end
                    OFF_ACC: begin
                        if (!s_q.run) begin
                            s_d.acc = extToAcc(hwdata);
                        end
                    end
                    default: ; // unmapped writes are dropped
                endcase
            end
        end

        // command sequencer
        case (s_q.fsm)
            ST_IDLE: ;
            ST_EXEC: begin
                s_d.cmd = vehi_cmd_t'(cmdWord);
                s_d.pc = s_q.pc + 11'h001;
                s_d.fsm = ST_XHOLD;
                // decode the fetched word straight away, argument by class
                case (cmdWord[15:11])
                    OP_HALT, OP_BREAK: stopNow = 1'b1;
                    OP_LX: begin
                        s_d.vecX = pairRead(cmdWord[10:0]);
                        s_d.fsm = ST_EXEC;
                    end
                    OP_LY: begin
                        s_d.vecY = pairRead(cmdWord[10:0]);
                        s_d.fsm = ST_EXEC;
                    end
                    OP_LZ: begin
                        s_d.vecZ = pairRead(cmdWord[10:0]);
                        s_d.fsm = ST_EXEC;
                    end
                    OP_LEA: begin
                        s_d.acc = extToAcc(pairRead(cmdWord[10:0]));
                        s_d.fsm = ST_EXEC;
                    end
                    OP_SEA: begin
                        // two words needed; the odd half follows next cycle
                        ramWe = 1'b1;
                        ramWa = {cmdWord[10:1], 1'b0};
                        ramWd = accExt[15:0];
                        s_d.fsm = ST_XREL;
                    end
                    OP_JMP: begin
                        s_d.pc = cmdWord[10:0];
                        s_d.fsm = ST_EXEC;
                    end
                    OP_EXTLD, OP_EXTST: s_d.fsm = ST_XHOLD;
                    default: begin
                        s_d.undFlag = 1'b1;
                        stopNow = 1'b1;
                    end
                endcase
            end
            ST_XHOLD: begin
                // wait here while the core holds references off
                if (!s_q.extHold) begin
                    s_d.holdReq = 1'b1;
                    if (s_q.holdReq && holdAck) begin
                        s_d.xreq.valid = 1'b1; // drive only after acknowledge
                        s_d.xreq.write = s_q.cmd.opcode == OP_EXTST;
                        s_d.xreq.addr = {21'h00_0000, s_q.cmd.arg};
                        s_d.xreq.wdata = ram[s_q.vecX[10:0]];
                        s_d.fsm = ST_XBUS;
                    end
                end else begin
                    s_d.holdReq = 1'b0;
                end
            end
            ST_XBUS: begin
                if (extDone) begin
                    if (!s_q.xreq.write) begin
                        ramWe = 1'b1;
                        ramWa = s_q.vecX[10:0];
                        ramWd = extRdata;
                    end
                    s_d.xreq.valid = 1'b0;
                    s_d.holdReq = 1'b0; // bus handed back for at least three cycles
                    s_d.fsm = ST_XREL;
                end
            end
            ST_XREL: begin
                // after a store, finish the odd half; after a bus cycle, just idle once
                if (s_q.cmd.opcode == OP_SEA) begin
                    ramWe = 1'b1;
                    ramWa = {evenAddr[10:1], 1'b1};
                    ramWd = accExt[31:16];
                end
                s_d.fsm = ST_EXEC;
            end
            default: s_d.fsm = ST_IDLE;
        endcase

        // every way out of execution except reset ends the same way
        if (stopNow && s_q.run) begin
            s_d.run = 1'b0;
            s_d.haltFlag = 1'b1;
            s_d.fsm = ST_IDLE;
            s_d.holdReq = 1'b0;
            s_d.xreq.valid = 1'b0;
        end

        // interrupt output from the masked sticky flag
        s_d.intOutN = !(s_d.haltFlag && s_d.haltMask);
    end

    // state register
    always_ff @(posedge clk) begin
        if (!resetn) begin
            s_q <= '0;
            s_q.fsm <= ST_IDLE;
            s_q.intOutN <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // memory write port; contents are not reset
    always_ff @(posedge clk) begin
        if (ramWe) begin
            ram[ramWa] <= ramWd;
        end
    end

    // outputs
    always_comb begin
        hrdata = s_q.rdata;
        hreadyout = 1'b1; // zero wait states
        hresp = 1'b0;
        holdReq = s_q.holdReq;
        extReq = s_q.xreq;
        interruptOutN = s_q.intOutN;
        nmiReq = s_q.errFlag || s_q.undFlag;
    end
endmodule : vehi_core
`default_nettype wire

// File: core/vehi_pkg.sv
// package: map, field layout, resets, states and carriers of the vector engine host interface
package vehi_pkg;
    // register byte offsets on the bus
    localparam logic [13:0] OFF_CMD_PTR = 14'h0000;
    localparam logic [13:0] OFF_STATUS = 14'h0004;
    localparam logic [13:0] OFF_ABORT = 14'h0008;
    localparam logic [13:0] OFF_EXT_HOLD = 14'h000c;
    localparam logic [13:0] OFF_INT_FLAGS = 14'h0010;
    localparam logic [13:0] OFF_INT_MASK = 14'h0014;
    localparam logic [13:0] OFF_NMI_CAUSE = 14'h0018;
    localparam logic [13:0] OFF_ACC = 14'h001c;
    localparam logic [13:0] OFF_RAM_BASE = 14'h2000;
    // field positions
    localparam int BIT_RUN = 0;
    localparam int BIT_HALT = 0;
    localparam int BIT_ERR = 0;
    localparam int BIT_UND = 1;
    localparam int BIT_EXTHOLD = 0;
    // memory geometry
    localparam int RAM_WORDS = 2048;
    localparam logic [10:0] RAM_TOP = 11'h7ff;
    // number formats
    localparam logic [15:0] REAL_MIN = 16'h8000;
    localparam logic [15:0] REAL_MAX = 16'h7fff;
    localparam logic [31:0] EXT_MIN = 32'h8000_0000;
    localparam logic [31:0] EXT_MAX = 32'h7fff_fffe;
    // opcodes
    localparam logic [4:0] OP_HALT = 5'h00;
    localparam logic [4:0] OP_BREAK = 5'h01;
    localparam logic [4:0] OP_LX = 5'h02;
    localparam logic [4:0] OP_LY = 5'h03;
    localparam logic [4:0] OP_LZ = 5'h04;
    localparam logic [4:0] OP_LEA = 5'h05;
    localparam logic [4:0] OP_SEA = 5'h06;
    localparam logic [4:0] OP_JMP = 5'h07;
    localparam logic [4:0] OP_EXTLD = 5'h08;
    localparam logic [4:0] OP_EXTST = 5'h09;
    // reset values
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [10:0] RST_PTR = 11'h000;

    typedef enum logic [2:0] {ST_IDLE, ST_EXEC, ST_XHOLD, ST_XBUS, ST_XREL} vehi_fsm_t;

    // command word carrier
    typedef struct packed {
        logic [4:0] opcode;
        logic [10:0] arg;
    } vehi_cmd_t;

    // external bus request carrier
    typedef struct packed {
        logic valid;
        logic write;
        logic [31:0] addr;
        logic [15:0] wdata;
    } vehi_xreq_t;

    // whole registered state of the core, memory aside
    typedef struct packed {
        vehi_fsm_t fsm;
        logic run;
        logic [10:0] pc;
        vehi_cmd_t cmd;
        logic [31:0] vecX;
        logic [31:0] vecY;
        logic [31:0] vecZ;
        logic [31:0] acc;
        logic haltFlag;
        logic haltMask;
        logic errFlag;
        logic undFlag;
        logic extHold;
        logic holdReq;
        vehi_xreq_t xreq;
        logic phValid;
        logic phWrite;
        logic [13:0] phAddr;
        logic [31:0] rdata;
        logic intOutN;
    } vehi_state_t;
endpackage : vehi_pkg

// File: testbench/vehi_properties.sv
// checker: port-level properties of the vector engine host interface
`timescale 1ns/1ps
`default_nettype none
module vehi_properties
    import vehi_pkg::*;
(
    input wire logic clk, // clock
    input wire logic resetn, // reset, low
    input wire logic hsel, // select
    input wire logic [31:0] haddr, // address
    input wire logic [1:0] htrans, // transfer
    input wire logic hwrite, // write
    input wire logic [31:0] hwdata, // wdata
    input wire logic hready, // ready in
    input wire logic hreadyout, // ready out
    input wire logic hresp, // response
    input wire logic holdReq, // hold request
    input wire logic holdAck, // hold grant
    input wire vehi_xreq_t extReq, // far request
    input wire logic extDone, // far done
    input wire logic interruptOutN, // halt irq
    input wire logic nmiReq // nmi
);
    logic wrPend_q; // write in data phase
    logic [13:0] wrAddr_q; // its offset
    logic intWr_q; // flag/mask write last cycle
    logic extHold_q; // shadow of hold flag
    logic intWr; // flag/mask write now
    assign intWr = wrPend_q && (wrAddr_q == OFF_INT_FLAGS || wrAddr_q == OFF_INT_MASK);
    // track writes; effect lands at the end of the data phase
    always_ff @(posedge clk) begin
        if (!resetn) begin
            wrPend_q <= 1'b0;
            wrAddr_q <= 14'h0000;
            intWr_q <= 1'b0;
            extHold_q <= 1'b0;
        end else begin
            wrPend_q <= hsel && hready && htrans[1] && hwrite;
            wrAddr_q <= haddr[13:0];
            intWr_q <= intWr;
            if (wrPend_q && wrAddr_q == OFF_EXT_HOLD) begin
                extHold_q <= hwdata[0];
            end
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // transfer finishing, then the bus handed back
    sequence s_xferEnd;
        extReq.valid && extDone;
    endsequence
    sequence s_busFree;
        !extReq.valid && !holdReq;
    endsequence
    AST_BUS_OKAY: assert property (hreadyout && !hresp)
        else $error("slave not ready or error");
    AST_ACK_FIRST: assert property ($rose(extReq.valid) |-> $past(holdReq && holdAck))
        else $error("far request before grant");
    AST_REQ_HELD: assert property (extReq.valid |-> holdReq)
        else $error("request without hold");
    AST_REQ_STABLE: assert property (extReq.valid && !extDone |=> $stable(extReq))
        else $error("far request changed early");
    AST_ONE_FREE: assert property (s_xferEnd |=> s_busFree)
        else $error("bus not released");
    AST_EXT_STALL: assert property (extHold_q && !holdReq |=> !holdReq)
        else $error("hold request while disabled");
    AST_NMI_STICKY: assert property (nmiReq && !(wrPend_q && wrAddr_q == OFF_NMI_CAUSE)
        |=> nmiReq)
        else $error("nmi dropped without clear");
    AST_IRQ_STICKY: assert property (!interruptOutN && !intWr && !intWr_q |=> !interruptOutN)
        else $error("irq dropped without clear");
endmodule // vehi_properties
bind vehi_core vehi_properties u_vehi_properties (.clk(clk), .resetn(resetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .holdReq(holdReq), .holdAck(holdAck),
    .extReq(extReq), .extDone(extDone), .interruptOutN(interruptOutN), .nmiReq(nmiReq));
`default_nettype wire

// File: testbench/vehi_arbiter_model.sv
// partner: core bus arbiter plus external memory behind the hold handshake
`timescale 1ns/1ps
`default_nettype none
module vehi_arbiter_model
    import vehi_pkg::*;
(
    input wire logic clk, // clock
    input wire logic resetn, // reset, low
    input wire logic extHoldPin, // outside hold, wins
    input wire logic holdReq, // engine request
    output logic holdAck, // grant
    input wire vehi_xreq_t extReq, // engine transfer
    output logic extDone, // done pulse
    output logic [15:0] extRdata // read data
);
    logic [15:0] xmem [int]; // written far words
    int seed = 32'h0000_528b; // fixed seed
    int rnd; // random draw
    int waitCnt; // wait states left
    // grant, wait states, completion
    always @(posedge clk) begin
        rnd = $random(seed);
        if (!resetn) begin
            holdAck <= 1'b0;
            extDone <= 1'b0;
            extRdata <= 16'h0000;
            waitCnt <= 0;
        end else begin
            extDone <= 1'b0;
            extRdata <= ~extRdata; // never a stale value outside done
            // outside hold blocks any new grant
            holdAck <= holdReq && (holdAck || (!extHoldPin && rnd[0]));
            if (extReq.valid && holdAck && !extDone) begin
                if (waitCnt > 0) begin
                    waitCnt <= waitCnt - 1;
                end else begin
                    extDone <= 1'b1;
                    if (extReq.write) begin
                        xmem[int'(extReq.addr[15:0])] = extReq.wdata;
                    end else begin
                        // every read returns a fixed pattern, written words included
                        extRdata <= extReq.addr[15:0] ^ 16'ha5a5;
                    end
                end
            end else begin
                waitCnt <= rnd[3:2]; // slow or prompt
            end
        end
    end
endmodule // vehi_arbiter_model
`default_nettype wire

// File: testbench/test_vector_engine_host_interface.sv
// testbench: bus-driven checks of the host interface against a bench model
`timescale 1ns/1ps
`default_nettype none
module test_vector_engine_host_interface
    import vehi_pkg::*;
;
    logic clk = 1'b0; // 200 MHz
    logic resetn = 1'b0; // active low
    logic hsel = 1'b0, hwrite = 1'b0, extHoldPin = 1'b0; // driven here
    logic [31:0] haddr = '0, hwdata = '0, hrdata, v; // bus, scratch
    logic [1:0] htrans = 2'h0; // idle
    logic [2:0] hsize = 3'h2; // word
    logic hready, hresp, holdReq, holdAck, extDone, interruptOutN, nmiReq; // outputs
    logic [15:0] extRdata; // far data
    logic [4:0] op; // opcode under test
    vehi_xreq_t extReq; // far request
    int n_fail = 0, compares = 0, seed = 32'h0000_528b, n; // counts
    int mdlRam [int]; // model of internal memory
    always #2.5 clk = ~clk; // 5 ns period
    always @(posedge clk) extHoldPin <= ($random(seed) & 3) == 0; // outside hold bursts
    vehi_core u_vehi_core (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .holdReq(holdReq),
        .holdAck(holdAck), .extReq(extReq), .extDone(extDone), .extRdata(extRdata),
        .interruptOutN(interruptOutN), .nmiReq(nmiReq));
    vehi_arbiter_model u_vehi_arbiter_model (.clk(clk), .resetn(resetn),
        .extHoldPin(extHoldPin), .holdReq(holdReq), .holdAck(holdAck), .extReq(extReq),
        .extDone(extDone), .extRdata(extRdata));
    task automatic tally_and_finish();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one edge with ready high; values taken just before it
    task automatic edgeRdy(output logic [31:0] rd);
        int k;
        logic r;
        k = 0;
        do begin
            @(negedge clk);
            r = hready;
            rd = hrdata;
            @(posedge clk);
            k++;
        end while (r !== 1'b1 && k < 64);
        if (r !== 1'b1) begin
            n_fail++;
            tally_and_finish();
        end
    endtask
    // single word transfer, entered just after an edge
    task automatic bus(input logic w, input logic [13:0] a, input logic [31:0] wd,
            output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {18'h0_0000, a};
        hwrite <= w;
        edgeRdy(rd);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        edgeRdy(rd);
    endtask
    task automatic wr(input logic [13:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask
    task automatic rd(input string nm, input logic [13:0] a, input logic [31:0] e);
        logic [31:0] x;
        bus(1'b0, a, '0, x);
        chk(nm, e, x);
    endtask
    function automatic logic [13:0] ra(input int i);
        return OFF_RAM_BASE + 14'(i * 4);
    endfunction
    task automatic wrRam(input int i, input logic [15:0] d);
        mdlRam[i] = d;
        wr(ra(i), {16'h0000, d});
    endtask
    task automatic rdRam(input int i);
        rd("ram", ra(i), 32'(mdlRam[i]));
    endtask
    // poll the run flag, bounded
    task automatic waitIdle();
        logic [31:0] s;
        int k;
        k = 0;
        do begin
            bus(1'b0, OFF_STATUS, '0, s);
            k++;
        end while (s[BIT_RUN] !== 1'b0 && k < 200);
        chk("run", 32'h0, s);
        if (s[BIT_RUN] !== 1'b0) tally_and_finish();
    endtask
    // pins are registered: let them settle
    task automatic pins(input logic irqN, input logic nmi);
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk("irqPin", {31'h0, irqN}, {31'h0, interruptOutN});
        chk("nmiPin", {31'h0, nmi}, {31'h0, nmiReq});
        chk("hresp", 32'h0, {31'h0, hresp});
        @(posedge clk);
    endtask
    initial begin
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        rd("status", OFF_STATUS, 32'h0);
        rd("nmi", OFF_NMI_CAUSE, 32'h0);
        pins(1'b1, 1'b0);
        // idle memory is plain memory, edges of the range included
        for (int i = 0; i < 4; i++) begin
            n = (i == 2) ? int'(RAM_TOP) : (i == 3) ? ($random(seed) & 32'h7ff) : i;
            v = $random(seed);
            wr(ra(n), v);
            mdlRam[n] = v[15:0];
            rdRam(n);
        end
        wr(OFF_INT_MASK, 32'h1);
        wrRam(32'h10, {OP_LEA, 11'h100});
        wrRam(32'h11, {OP_SEA, 11'h102});
        wrRam(32'h12, {OP_HALT, 11'h000});
        // extended values through the accumulator, range ends first
        for (int i = 0; i < 3; i++) begin
            v = (i == 0) ? EXT_MIN : (i == 1) ? EXT_MAX : $random(seed);
            wr(OFF_ACC, v);
            rd("acc", OFF_ACC, v & 32'hffff_fffe);
            wrRam(32'h100, v[15:0]);
            wrRam(32'h101, v[31:16]);
            wr(OFF_CMD_PTR, 32'h10);
            waitIdle();
            mdlRam[32'h102] = {v[15:1], 1'b0};
            mdlRam[32'h103] = v[31:16];
            rdRam(32'h102);
            rdRam(32'h103);
            rd("halt", OFF_INT_FLAGS, 32'h1);
            pins(1'b0, 1'b0);
            wr(OFF_INT_FLAGS, 32'h1);
            pins(1'b1, 1'b0);
        end
        // stop, breakpoint and a reserved code
        for (int i = 0; i < 3; i++) begin
            op = (i == 0) ? OP_HALT : (i == 1) ? OP_BREAK : 5'h1f;
            wrRam(32'h30, {op, 11'h000});
            wr(OFF_CMD_PTR, 32'h30);
            waitIdle();
            rd("nmi", OFF_NMI_CAUSE, (i == 2) ? 32'h2 : 32'h0);
            rd("mask", OFF_INT_MASK, 32'h1);
            pins(1'b0, i == 2);
            wr(OFF_INT_FLAGS, 32'h1);
            wr(OFF_NMI_CAUSE, 32'h3);
            pins(1'b1, 1'b0);
        end
        // endless loop ended by abort or by an illegal access
        wrRam(32'h20, {OP_JMP, 11'h020});
        for (int i = 0; i < 4; i++) begin
            wr(OFF_CMD_PTR, 32'h20);
            rd("busy", OFF_STATUS, 32'h1);
            wr(OFF_EXT_HOLD, 32'h0);
            rd("nmiRun", OFF_NMI_CAUSE, 32'h0);
            case (i)
                0: wr(OFF_ABORT, 32'h0);
                1: rd("badRd", ra(32'h20), 32'h0);
                2: wr(ra(32'h20), 32'hffff);
                default: wr(OFF_CMD_PTR, 32'h5);
            endcase
            waitIdle();
            rd("nmi", OFF_NMI_CAUSE, (i == 0) ? 32'h0 : 32'h1);
            rd("halt", OFF_INT_FLAGS, 32'h1);
            rdRam(32'h20);
            wr(OFF_INT_FLAGS, 32'h1);
            wr(OFF_NMI_CAUSE, 32'h3);
        end
        // reset in mid-run ends the loop and clears every flag
        wr(OFF_CMD_PTR, 32'h20);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        rd("rstRun", OFF_STATUS, 32'h0);
        rd("rstNmi", OFF_NMI_CAUSE, 32'h0);
        pins(1'b1, 1'b0);
        // far read then far write, held off by the hold flag first
        wrRam(32'h60, 16'h0070);
        wrRam(32'h61, 16'h0000);
        wrRam(32'h40, {OP_LX, 11'h060});
        wrRam(32'h41, {OP_EXTLD, 11'h123}); // distinct far words
        wrRam(32'h42, {OP_EXTST, 11'h124});
        wrRam(32'h43, {OP_HALT, 11'h000});
        wr(OFF_EXT_HOLD, 32'h1);
        wr(OFF_CMD_PTR, 32'h40);
        repeat (20) @(posedge clk);
        rd("stall", OFF_STATUS, 32'h1);
        @(negedge clk);
        chk("holdReq", 32'h0, {31'h0, holdReq});
        @(posedge clk);
        wr(OFF_EXT_HOLD, 32'h0);
        waitIdle();
        mdlRam[32'h70] = 16'h0123 ^ 16'ha5a5;
        rdRam(32'h70);
        chk("farWr", 32'(mdlRam[32'h70]), {16'h0, u_vehi_arbiter_model.xmem[32'h124]});
        tally_and_finish();
    end
endmodule // test_vector_engine_host_interface
`default_nettype wire
